// >>> design/alu_subset.sv
// Execution datapath for divide, compare, negate, extend and logic ops.
// Assumes the decoder pulses start only while busy_r is low, operands valid.
// Notes on behaviour
// - Byte divide: 16-bit by 8-bit, quotient/remainder.
// - Word divide: 32-bit by 16-bit, quotient/remainder.
// - Compare subtracts source, sets flags, no write.
// - Negate writes zero minus destination.
// - Zero extension fills upper bits with zeros.
// - Sign extension copies low part sign upward.
// - AND destination with register or immediate.
// - OR destination with register or immediate.
// - XOR destination with register or immediate.
// - Complement inverts every destination bit.
// - Divide byte/word only; extends word/long only.
// - Registers addressed as bytes, words or longs.
`include "alu_defines.svh"

module alu_subset (
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire logic                    start,
  input  wire alu_pkg::op_t            opSel,
  input  wire alu_pkg::size_t          opSize,
  input  wire logic [3:0]              dstIdx,
  input  wire logic [3:0]              srcReg,
  input  wire logic                    useImm,
  input  wire logic [31:0]             immediateValue,
  input  wire logic [2:0]              rdIdx,
  output logic                         done_r,
  output logic                         illegal_r,
  output logic                         busy_r,
  output logic [3:0]                   condFlags_r,
  output logic [31:0]                  rdData_r
);
  import alu_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIV  = 2'b01
  } state_t;

  // ----------------------------------------
  // Operand views
  // ----------------------------------------
  // byte, word, long views
  function automatic logic [31:0] getOp(logic [31:0] r, logic low, size_t sz);
    case (sz)
      SZ_BYTE: getOp = low ? {24'h0, r[7:0]} : {24'h0, r[15:8]};
      SZ_WORD: getOp = low ? {16'h0, r[31:16]} : {16'h0, r[15:0]};
      default: getOp = r;
    endcase
  endfunction : getOp

  function automatic logic [31:0] putOp(logic [31:0] r, logic low, size_t sz,
                                        logic [31:0] v);
    case (sz)
      SZ_BYTE: putOp = low ? {r[31:8], v[7:0]} : {r[31:16], v[7:0], r[7:0]};
      SZ_WORD: putOp = low ? {v[15:0], r[15:0]} : {r[31:16], v[15:0]};
      default: putOp = v;
    endcase
  endfunction : putOp

  function automatic logic [31:0] sizeMask(size_t sz);
    case (sz)
      SZ_BYTE: sizeMask = 32'h0000_00ff;
      SZ_WORD: sizeMask = 32'h0000_ffff;
      default: sizeMask = 32'hffff_ffff;
    endcase
  endfunction : sizeMask

  function automatic logic signOf(logic [31:0] v, size_t sz);
    case (sz)
      SZ_BYTE: signOf = v[7];
      SZ_WORD: signOf = v[15];
      default: signOf = v[31];
    endcase
  endfunction : signOf

  logic [7:0][31:0] regs_r,    regs_nxt;
  state_t           state_r,   state_nxt;
  logic             done_nxt,  illegal_nxt, busy_nxt;
  logic [3:0]       condFlags_nxt;
  logic [31:0]      rdData_nxt;
  logic [3:0]       divDst_r,  divDst_nxt;
  size_t            divSize_r, divSize_nxt;
  logic             divStart_r, divStart_nxt;
  logic [31:0]      dividend_r, dividend_nxt;
  logic [15:0]      divisor_r,  divisor_nxt;

  logic [31:0] dstFull, srcFull, aOp, bOp, subA, subB, mask, res;
  logic [32:0] diff;
  logic        legal, isArith, sA, sB, sR;
  logic [3:0]  flags;
  logic [31:0] divDivd;
  logic [15:0] divDvsr;
  logic [31:0] aOpW, bOpB, bOpW;

  div_if dv ();

  assign dv.start    = divStart_r;
  assign dv.dividend = dividend_r;
  assign dv.divisor  = divisor_r;

  signed_divider i_signed_divider (
    .ref_clk (ref_clk),
    .rst     (rst),
    .dv      (dv)
  );

  // ----------------------------------------
  // Datapath
  // ----------------------------------------
  assign dstFull = regs_r[dstIdx[2:0]];
  assign srcFull = regs_r[srcReg[2:0]];
  assign mask    = sizeMask(opSize);
  assign aOp     = getOp(dstFull, dstIdx[3], opSize);
  assign bOp     = (useImm ? immediateValue : getOp(srcFull, srcReg[3], opSize)) & mask;
  assign subA    = (opSel == OP_NEGATE) ? 32'h0 : aOp;
  assign subB    = (opSel == OP_NEGATE) ? aOp : bOp;
  assign diff    = {1'b0, subA} - {1'b0, subB};
  assign isArith = (opSel == OP_COMPARE) || (opSel == OP_NEGATE);

  // Result select per operation
  always_comb begin
    case (opSel)
      OP_COMPARE, OP_NEGATE: res = diff[31:0] & mask;
      OP_AND:      res = aOp & bOp;
      OP_OR:       res = aOp | bOp;
      OP_XOR:      res = aOp ^ bOp;
      OP_NOT:      res = ~aOp & mask;
      OP_ZERO_EXT: res = (opSize == SZ_WORD) ? {24'h0, aOp[7:0]} : {16'h0, aOp[15:0]};
      OP_SIGN_EXT: res = (opSize == SZ_WORD) ? {16'h0, {8{aOp[7]}}, aOp[7:0]}
                                             : {{16{aOp[15]}}, aOp[15:0]};
      default:     res = aOp;
    endcase
  end

  // Flags from the sized result
  always_comb begin
    sA = signOf(subA, opSize);
    sB = signOf(subB, opSize);
    sR = signOf(res, opSize);
    flags = condFlags_r;
    flags[`FLAG_N] = sR;
    flags[`FLAG_Z] = (res == 32'h0);
    flags[`FLAG_V] = isArith ? ((sA ^ sB) & (sA ^ sR)) : 1'b0;
    if (isArith) begin
      flags[`FLAG_C] = diff[32];
    end
  end

  always_comb begin
    case (opSel)
      OP_DIV_SIGNED:            legal = (opSize == SZ_BYTE) || (opSize == SZ_WORD);
      OP_ZERO_EXT, OP_SIGN_EXT: legal = (opSize == SZ_WORD) || (opSize == SZ_LONG);
      default:                  legal = (opSize != SZ_NONE);
    endcase
  end

  // byte divide, word dividend by byte divisor
  assign divDivd = (opSize == SZ_BYTE)
                   ? {{16{aOpW[15]}}, aOpW[15:0]} : dstFull;
  assign aOpW    = getOp(dstFull, dstIdx[3], SZ_WORD);
  assign bOpB    = getOp(srcFull, srcReg[3], SZ_BYTE);
  assign bOpW    = getOp(srcFull, srcReg[3], SZ_WORD);
  // word divide, long dividend by word divisor
  assign divDvsr = (opSize == SZ_BYTE) ? {{8{bOpB[7]}}, bOpB[7:0]} : bOpW[15:0];

  // ----------------------------------------
  // Control next state
  // ----------------------------------------
  always_comb begin
    regs_nxt      = regs_r;
    state_nxt     = state_r;
    done_nxt      = 1'b0;
    illegal_nxt   = 1'b0;
    busy_nxt      = busy_r;
    condFlags_nxt = condFlags_r;
    rdData_nxt    = regs_r[rdIdx];
    divDst_nxt    = divDst_r;
    divSize_nxt   = divSize_r;
    divStart_nxt  = 1'b0;
    dividend_nxt  = dividend_r;
    divisor_nxt   = divisor_r;
    case (state_r)
      ST_IDLE: begin
        if (start && !legal) begin
          illegal_nxt = 1'b1;
        end else if (start && opSel == OP_DIV_SIGNED) begin
          divStart_nxt = 1'b1;
          dividend_nxt = divDivd;
          divisor_nxt  = divDvsr;
          divDst_nxt   = dstIdx;
          divSize_nxt  = opSize;
          busy_nxt     = 1'b1;
          state_nxt    = ST_DIV;
        end else if (start) begin
          if (opSel != OP_COMPARE) begin
            regs_nxt[dstIdx[2:0]] = putOp(dstFull, dstIdx[3], opSize, res);
          end
          condFlags_nxt = flags;
          done_nxt      = 1'b1;
        end
      end
      ST_DIV: begin
        if (dv.done) begin
          // remainder high half, quotient low half
          if (divisor_r != 16'h0) begin
            if (divSize_r == SZ_BYTE) begin
              regs_nxt[divDst_r[2:0]] = putOp(regs_r[divDst_r[2:0]], divDst_r[3],
                                              SZ_WORD, {16'h0, dv.rem[7:0], dv.quot[7:0]});
            end else begin
              regs_nxt[divDst_r[2:0]] = {dv.rem, dv.quot};
            end
          end
          condFlags_nxt[`FLAG_N] = (divSize_r == SZ_BYTE) ? dv.quot[7] : dv.quot[15];
          condFlags_nxt[`FLAG_Z] = (divisor_r == 16'h0);
          done_nxt  = 1'b1;
          busy_nxt  = 1'b0;
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Control registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      regs_r      <= {`REG_COUNT{`REG_RESET}};
      state_r     <= ST_IDLE;
      done_r      <= 1'b0;
      illegal_r   <= 1'b0;
      busy_r      <= 1'b0;
      condFlags_r <= `FLAGS_RESET;
      rdData_r    <= 32'h0;
      divDst_r    <= 4'h0;
      divSize_r   <= SZ_NONE;
      divStart_r  <= 1'b0;
      dividend_r  <= 32'h0;
      divisor_r   <= 16'h0;
    end else begin
      regs_r      <= regs_nxt;
      state_r     <= state_nxt;
      done_r      <= done_nxt;
      illegal_r   <= illegal_nxt;
      busy_r      <= busy_nxt;
      condFlags_r <= condFlags_nxt;
      rdData_r    <= rdData_nxt;
      divDst_r    <= divDst_nxt;
      divSize_r   <= divSize_nxt;
      divStart_r  <= divStart_nxt;
      dividend_r  <= dividend_nxt;
      divisor_r   <= divisor_nxt;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_div_done_bound: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == ST_IDLE && start && legal && opSel == OP_DIV_SIGNED)
    |-> ##[30:40] (done_r && !busy_r))
    else $error("divide did not finish in time");
  a_cmp_no_write: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == ST_IDLE && start && legal && opSel == OP_COMPARE)
    |=> (regs_r == $past(regs_r)) && done_r)
    else $error("compare changed a register");
  a_neg_long_value: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == ST_IDLE && start && opSel == OP_NEGATE && opSize == SZ_LONG)
    |=> regs_r[$past(dstIdx[2:0])] == 32'h0 - $past(dstFull))
    else $error("negate result wrong");
  a_zext_upper_zero: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == ST_IDLE && start && opSel == OP_ZERO_EXT && opSize == SZ_LONG)
    |=> regs_r[$past(dstIdx[2:0])][31:16] == 16'h0)
    else $error("zero extension left upper bits");
  a_sext_upper_sign: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == ST_IDLE && start && opSel == OP_SIGN_EXT && opSize == SZ_LONG)
    |=> regs_r[$past(dstIdx[2:0])][31:16] == {16{$past(dstFull[15])}})
    else $error("sign extension wrong");
  a_and_imm_long: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == ST_IDLE && start && opSel == OP_AND && opSize == SZ_LONG && useImm)
    |=> regs_r[$past(dstIdx[2:0])] == ($past(dstFull) & $past(immediateValue)))
    else $error("and result wrong");
  a_bad_size_refused: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == ST_IDLE && start && opSel == OP_DIV_SIGNED && opSize == SZ_LONG)
    |=> illegal_r && !done_r && !busy_r && (regs_r == $past(regs_r)))
    else $error("long divide not refused");
  a_byte_upper_kept: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == ST_IDLE && start && opSize == SZ_BYTE && opSel != OP_DIV_SIGNED)
    |=> regs_r[$past(dstIdx[2:0])][31:16] == $past(dstFull[31:16]))
    else $error("byte op touched upper word");

endmodule : alu_subset

// >>> design/alu_defines.svh
// Constants for the arithmetic and logic subset datapath.
// Assumes inclusion by bare name from design files only.
`ifndef ALU_DEFINES_SVH
`define ALU_DEFINES_SVH

// Condition flag bit positions
`define FLAG_C       2'd0
`define FLAG_V       2'd1
`define FLAG_Z       2'd2
`define FLAG_N       2'd3
`define FLAGS_RESET  4'h0

// General register file shape and reset value
`define REG_COUNT    8
`define REG_RESET    32'h0000_0000

// Divider steps, one quotient bit per cycle
`define DIV_STEPS    6'd32

`endif

// >>> design/alu_pkg.sv
// Types shared by the datapath, the divider and their link.
// Assumes no surroundings beyond the compiler.
package alu_pkg;

  // Operation select from the decoder
  typedef enum logic [3:0] {
    OP_DIV_SIGNED = 4'h0,
    OP_COMPARE    = 4'h1,
    OP_NEGATE     = 4'h2,
    OP_ZERO_EXT   = 4'h3,
    OP_SIGN_EXT   = 4'h4,
    OP_AND        = 4'h5,
    OP_OR         = 4'h6,
    OP_XOR        = 4'h7,
    OP_NOT        = 4'h8
  } op_t;

  // Operand size code
  typedef enum logic [1:0] {
    SZ_NONE = 2'b00,
    SZ_BYTE = 2'b01,
    SZ_WORD = 2'b10,
    SZ_LONG = 2'b11
  } size_t;

endpackage : alu_pkg

// >>> design/div_if.sv
// Link between the datapath and its iterative signed divider.
// Assumes both ends share one clock.
interface div_if;
  logic        start;
  logic [31:0] dividend;
  logic [15:0] divisor;
  logic        done;
  logic [15:0] quot;
  logic [15:0] rem;

  modport ctl (output start, output dividend, output divisor,
               input done, input quot, input rem);
  modport eng (input start, input dividend, input divisor,
               output done, output quot, output rem);
endinterface : div_if

// >>> design/signed_divider.sv
// Iterative signed divider, 32-bit dividend by 16-bit divisor.
// Assumes operands arrive sign-extended and stable with the start pulse.
`include "alu_defines.svh"

module signed_divider (
  input  wire logic ref_clk,
  input  wire logic rst,
  div_if.eng        dv
);
  import alu_pkg::*;

  typedef enum logic [1:0] {
    D_IDLE = 2'b00,
    D_RUN  = 2'b01,
    D_DONE = 2'b10
  } dstate_t;

  dstate_t     dstate_r,  dstate_nxt;
  logic [5:0]  count_r,   count_nxt;
  logic [31:0] q_r,       q_nxt;
  logic [16:0] part_r,    part_nxt;
  logic [15:0] dvsr_r,    dvsr_nxt;
  logic        negQ_r,    negQ_nxt;
  logic        negR_r,    negR_nxt;
  logic        done_r,    done_nxt;
  logic [15:0] quot_r,    quot_nxt;
  logic [15:0] rem_r,     rem_nxt;
  logic [16:0] trial;
  logic [31:0] qFinal;
  logic [15:0] rFinal;

  assign dv.done = done_r;
  assign dv.quot = quot_r;
  assign dv.rem  = rem_r;

  // ----------------------------------------
  // Restoring division on magnitudes
  // ----------------------------------------
  always_comb begin
    dstate_nxt = dstate_r;
    count_nxt  = count_r;
    q_nxt      = q_r;
    part_nxt   = part_r;
    dvsr_nxt   = dvsr_r;
    negQ_nxt   = negQ_r;
    negR_nxt   = negR_r;
    done_nxt   = 1'b0;
    quot_nxt   = quot_r;
    rem_nxt    = rem_r;
    trial      = {part_r[15:0], q_r[31]};
    qFinal     = negQ_r ? 32'h0 - q_r : q_r;
    rFinal     = negR_r ? 16'h0 - part_r[15:0] : part_r[15:0];
    case (dstate_r)
      D_IDLE: begin
        if (dv.start) begin
          q_nxt      = dv.dividend[31] ? 32'h0 - dv.dividend : dv.dividend;
          dvsr_nxt   = dv.divisor[15] ? 16'h0 - dv.divisor : dv.divisor;
          negQ_nxt   = dv.dividend[31] ^ dv.divisor[15];
          negR_nxt   = dv.dividend[31];
          part_nxt   = 17'h0;
          count_nxt  = `DIV_STEPS;
          dstate_nxt = D_RUN;
        end
      end
      D_RUN: begin
        if (trial >= {1'b0, dvsr_r}) begin
          part_nxt = trial - {1'b0, dvsr_r};
          q_nxt    = {q_r[30:0], 1'b1};
        end else begin
          part_nxt = trial;
          q_nxt    = {q_r[30:0], 1'b0};
        end
        count_nxt = count_r - 6'd1;
        if (count_r == 6'd1) begin
          dstate_nxt = D_DONE;
        end
      end
      D_DONE: begin
        quot_nxt   = qFinal[15:0];
        rem_nxt    = rFinal;
        done_nxt   = 1'b1;
        dstate_nxt = D_IDLE;
      end
      default: dstate_nxt = D_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dstate_r <= D_IDLE;
      count_r  <= 6'd0;
      q_r      <= 32'h0;
      part_r   <= 17'h0;
      dvsr_r   <= 16'h0;
      negQ_r   <= 1'b0;
      negR_r   <= 1'b0;
      done_r   <= 1'b0;
      quot_r   <= 16'h0;
      rem_r    <= 16'h0;
    end else begin
      dstate_r <= dstate_nxt;
      count_r  <= count_nxt;
      q_r      <= q_nxt;
      part_r   <= part_nxt;
      dvsr_r   <= dvsr_nxt;
      negQ_r   <= negQ_nxt;
      negR_r   <= negR_nxt;
      done_r   <= done_nxt;
      quot_r   <= quot_nxt;
      rem_r    <= rem_nxt;
    end
  end

  // Done follows a start by a fixed latency
  a_div_latency: assert property (@(posedge ref_clk) disable iff (rst)
    (dstate_r == D_IDLE && dv.start) |-> ##34 done_r)
    else $error("divider latency wrong");

endmodule : signed_divider

// >>> verif/decoder_model.sv
// Decoder model: issues one operation at a time and reads registers back.
// Assumes one clock and one-cycle done and refusal pulses from the datapath.
module decoder_model (
  input  wire logic        ref_clk,
  input  wire logic        done_r,
  input  wire logic        illegal_r,
  input  wire logic [31:0] rdData_r,
  output alu_pkg::op_t     opSel,
  output alu_pkg::size_t   opSize,
  output logic             start,
  output logic [3:0]       dstIdx,
  output logic [3:0]       srcReg,
  output logic             useImm,
  output logic [31:0]      immediateValue,
  output logic [2:0]       rdIdx
);
  timeunit 1ns;
  timeprecision 1ns;
  import alu_pkg::*;

  // Idle request lines from time zero
  initial begin
    start          = 1'b0;
    opSel          = OP_NOT;
    opSize         = SZ_LONG;
    dstIdx         = 4'h0;
    srcReg         = 4'h0;
    useImm         = 1'b0;
    immediateValue = 32'h0;
    rdIdx          = 3'h0;
  end

  task automatic issue(input op_t op, input size_t sz, input logic [3:0] d,
                       input logic [3:0] s, input logic imm, input logic [31:0] v,
                       output int cyc, output logic refused);
    int n;
    @(posedge ref_clk);
    #1;
    start          = 1'b1;
    opSel          = op;
    opSize         = sz;
    dstIdx         = d;
    srcReg         = s;
    useImm         = imm;
    immediateValue = v;
    @(posedge ref_clk);
    #1;
    start   = 1'b0;
    cyc     = 0;
    refused = 1'b0;
    // Count cycles from the taking edge, bounded
    for (n = 1; n <= 40 && cyc == 0; n++) begin
      if (done_r === 1'b1 || illegal_r === 1'b1) begin
        cyc     = n;
        refused = illegal_r;
      end else begin
        @(posedge ref_clk);
        #1;
      end
    end
    // Operand no longer qualified: scramble it
    immediateValue = ~v;
  endtask : issue

  // Read back one 32-bit register
  task automatic peek(input logic [2:0] r, output logic [31:0] v);
    @(posedge ref_clk);
    #1;
    rdIdx = r;
    @(posedge ref_clk);
    #1;
    v = rdData_r;
  endtask : peek
endmodule : decoder_model

// >>> verif/arith_logic_unit_subset_bench.sv
// Self-checking bench for the arithmetic and logic subset datapath.
// Assumes the decoder model drives every request input of the datapath.
`define CHK(what, exp, got) \
  begin \
    numChecks++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("mismatch %s expected %h seen %h", what, exp, got); \
    end \
  end

module arith_logic_unit_subset_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import alu_pkg::*;

  logic        ref_clk;
  logic        rst;
  logic        start;
  op_t         opSel;
  size_t       opSize;
  logic [3:0]  dstIdx;
  logic [3:0]  srcReg;
  logic        useImm;
  logic [31:0] immediateValue;
  logic [2:0]  rdIdx;
  logic        done_r;
  logic        illegal_r;
  logic        busy_r;
  logic [3:0]  condFlags_r;
  logic [31:0] rdData_r;
  int          miscompares = 0;
  int          numChecks = 0;

  alu_subset i_alu_subset (.ref_clk(ref_clk), .rst(rst), .start(start), .opSel(opSel),
    .opSize(opSize), .dstIdx(dstIdx), .srcReg(srcReg), .useImm(useImm),
    .immediateValue(immediateValue), .rdIdx(rdIdx), .done_r(done_r),
    .illegal_r(illegal_r), .busy_r(busy_r), .condFlags_r(condFlags_r),
    .rdData_r(rdData_r));

  decoder_model i_decoder_model (.ref_clk(ref_clk), .done_r(done_r),
    .illegal_r(illegal_r), .rdData_r(rdData_r), .opSel(opSel), .opSize(opSize),
    .start(start), .dstIdx(dstIdx), .srcReg(srcReg), .useImm(useImm),
    .immediateValue(immediateValue), .rdIdx(rdIdx));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic conclude();
    if (miscompares == 0 && numChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  // One operation, judged for refusal and answer time
  task automatic run(input op_t o, input size_t z, input logic [3:0] d,
                     input logic [3:0] s, input logic im, input logic [31:0] v,
                     input logic ill, input int cyc);
    int   n;
    logic refused;
    i_decoder_model.issue(o, z, d, s, im, v, n, refused);
    if (n == 0) begin
      miscompares++;
      conclude();
    end
    `CHK("refusal", ill, refused)
    if (cyc != 0) `CHK("latency", cyc, n)
  endtask : run

  // One whole register set through clear then set
  task automatic load(input logic [2:0] r, input logic [31:0] v);
    run(OP_AND, SZ_LONG, {1'b0, r}, 4'h0, 1'b1, 32'h0, 1'b0, 1);
    run(OP_OR, SZ_LONG, {1'b0, r}, 4'h0, 1'b1, v, 1'b0, 1);
  endtask : load

  task automatic chk(input logic [2:0] r, input logic [31:0] e, input logic [3:0] f);
    logic [31:0] v;
    `CHK("flags", f, condFlags_r)
    i_decoder_model.peek(r, v);
    `CHK("register", e, v)
  endtask : chk

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic after_reset();
    `CHK("idle outputs", 7'h0, {done_r, illegal_r, busy_r, condFlags_r})
    chk(3'd3, 32'h0, 4'h0);
  endtask : after_reset

  // Byte and word halves, register and masked immediate sources
  task automatic logic_ops();
    load(3'd1, 32'h1234_5678);
    load(3'd2, 32'h0000_00ff);
    run(OP_AND, SZ_BYTE, 4'h9, 4'h0, 1'b1, 32'hffff_ff0f, 1'b0, 1);
    chk(3'd1, 32'h1234_5608, 4'h0);
    run(OP_OR, SZ_WORD, 4'h9, 4'h0, 1'b1, 32'habcd_00f0, 1'b0, 1);
    chk(3'd1, 32'h12f4_5608, 4'h0);
    run(OP_XOR, SZ_BYTE, 4'h1, 4'ha, 1'b0, 32'h0, 1'b0, 1);
    chk(3'd1, 32'h12f4_a908, 4'h8);
    run(OP_NOT, SZ_LONG, 4'h1, 4'h0, 1'b0, 32'h0, 1'b0, 1);
    chk(3'd1, 32'hed0b_56f7, 4'h8);
  endtask : logic_ops

  // Extensions at both sizes, then refused sizes
  task automatic extensions();
    load(3'd5, 32'h1234_ab80);
    run(OP_SIGN_EXT, SZ_WORD, 4'h5, 4'h0, 1'b0, 32'h0, 1'b0, 1);
    chk(3'd5, 32'h1234_ff80, 4'h8);
    run(OP_ZERO_EXT, SZ_LONG, 4'h5, 4'h0, 1'b0, 32'h0, 1'b0, 1);
    chk(3'd5, 32'h0000_ff80, 4'h0);
    run(OP_SIGN_EXT, SZ_LONG, 4'h5, 4'h0, 1'b0, 32'h0, 1'b0, 1);
    chk(3'd5, 32'hffff_ff80, 4'h8);
    run(OP_ZERO_EXT, SZ_WORD, 4'hd, 4'h0, 1'b0, 32'h0, 1'b0, 1);
    chk(3'd5, 32'h00ff_ff80, 4'h0);
    run(OP_ZERO_EXT, SZ_BYTE, 4'hd, 4'h0, 1'b0, 32'h0, 1'b1, 1);
    chk(3'd5, 32'h00ff_ff80, 4'h0);
    run(OP_SIGN_EXT, SZ_NONE, 4'h5, 4'h0, 1'b0, 32'h0, 1'b1, 1);
    chk(3'd5, 32'h00ff_ff80, 4'h0);
  endtask : extensions

  // Negate with borrow and overflow, compare without write
  task automatic negate_compare();
    run(OP_NEGATE, SZ_LONG, 4'h5, 4'h0, 1'b0, 32'h0, 1'b0, 1);
    chk(3'd5, 32'hff00_0080, 4'h9);
    load(3'd3, 32'haaaa_0001);
    run(OP_NEGATE, SZ_WORD, 4'h3, 4'h0, 1'b0, 32'h0, 1'b0, 1);
    chk(3'd3, 32'haaaa_ffff, 4'h9);
    load(3'd4, 32'h0000_0080);
    run(OP_NEGATE, SZ_BYTE, 4'hc, 4'h0, 1'b0, 32'h0, 1'b0, 1);
    chk(3'd4, 32'h0000_0080, 4'hb);
    run(OP_COMPARE, SZ_LONG, 4'h3, 4'h0, 1'b1, 32'haaaa_ffff, 1'b0, 1);
    chk(3'd3, 32'haaaa_ffff, 4'h4);
    run(OP_COMPARE, SZ_BYTE, 4'hc, 4'h0, 1'b1, 32'h0000_0001, 1'b0, 1);
    chk(3'd4, 32'h0000_0080, 4'h2);
    run(OP_COMPARE, SZ_WORD, 4'h3, 4'h4, 1'b0, 32'h0, 1'b0, 1);
    chk(3'd3, 32'haaaa_ffff, 4'h8);
  endtask : negate_compare

  // Signed divides, busy while running, zero divisor, long refused
  task automatic divisions();
    logic [31:0] v;
    load(3'd7, 32'h0000_0007);
    load(3'd6, 32'h5555_fff7);
    fork
      run(OP_DIV_SIGNED, SZ_BYTE, 4'h6, 4'hf, 1'b0, 32'h0, 1'b0, 36);
      begin
        repeat (3) @(posedge ref_clk);
        #2;
        `CHK("busy", 1'b1, busy_r)
      end
    join
    chk(3'd6, 32'h5555_feff, 4'h8);
    load(3'd6, 32'hfffe_7960);
    run(OP_DIV_SIGNED, SZ_WORD, 4'h6, 4'h7, 1'b0, 32'h0, 1'b0, 36);
    chk(3'd6, 32'hfffb_c833, 4'h8);
    run(OP_DIV_SIGNED, SZ_WORD, 4'h6, 4'h0, 1'b0, 32'h0, 1'b0, 0);
    `CHK("zero divisor", 1'b1, condFlags_r[2])
    i_decoder_model.peek(3'd6, v);
    `CHK("register", 32'hfffb_c833, v)
    run(OP_DIV_SIGNED, SZ_LONG, 4'h6, 4'h7, 1'b0, 32'h0, 1'b1, 1);
    i_decoder_model.peek(3'd6, v);
    `CHK("register", 32'hfffb_c833, v)
  endtask : divisions

  // ------------------------------------------------------------
  // Clock, reset and sequence
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  initial begin
    rst = 1'b1;
    repeat (5) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    after_reset();
    logic_ops();
    extensions();
    negate_compare();
    divisions();
    conclude();
  end
endmodule : arith_logic_unit_subset_bench
